// >>> design/chg_dpm_adc_regs.sv
// Charger register slice: input limit control and ADC readback registers
// behind a two-wire serial target with auto-incrementing register pointer.
// Assumes scl and sda arrive synchronous to sys_clk and far slower than it.
module chg_dpm_adc_regs (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [6:0] rel_limit_code_i,
  input  wire logic       thermal_regulation_flag_i,
  input  wire logic [6:0] battery_voltage_reading_i,
  input  wire logic [6:0] system_voltage_reading_i,
  input  wire logic       input_supply_present_i,
  input  wire logic [6:0] input_voltage_reading_i,
  input  wire logic [6:0] charge_current_reading_i,
  input  wire logic       below_battery_short_threshold_i,
  output logic            absolute_limit_select_o,
  output logic [6:0]      input_voltage_limit_threshold_o,
  output logic            safety_timer_restart_o
);

  chg_lim_if lim_if ();

  chg_limit_reg u_limit (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .rel_code_i (rel_limit_code_i),
    .lim        (lim_if.lim)
  );

  chg_pkg::chg_bus_state_t state_q;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       first_q;
  logic       nack_q;
  logic       oe_q;
  logic       wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic       lim_wr_q;
  logic       rst_req_q;
  logic       timer_q;
  logic [7:0] battery_voltage_reading_q;
  logic [7:0] system_voltage_reading_q;
  logic [7:0] input_voltage_reading_q;
  logic [7:0] ichg_q;
  logic [7:0] rdata;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [7:0] shift_next;

  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign bus_start  = scl_i & scl_q & sda_q & ~sda_i;
  assign bus_stop   = scl_i & scl_q & ~sda_q & sda_i;
  assign shift_next = {shift_q[6:0], sda_i};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Results are resampled every cycle, so a read returns the newest value.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      battery_voltage_reading_q  <= {1'b0, chg_pkg::RESULT_RESET};
      system_voltage_reading_q  <= {1'b0, chg_pkg::RESULT_RESET};
      input_voltage_reading_q <= {1'b0, chg_pkg::RESULT_RESET};
      ichg_q  <= {1'b0, chg_pkg::RESULT_RESET};
    end else begin
      battery_voltage_reading_q  <= {thermal_regulation_flag_i,
                  battery_voltage_reading_i};
      system_voltage_reading_q  <= {1'b0, system_voltage_reading_i};
      input_voltage_reading_q <= {input_supply_present_i,
                  input_voltage_reading_i};
      ichg_q  <= below_battery_short_threshold_i ?
                 {1'b0, chg_pkg::RESULT_RESET} :
                 {1'b0, charge_current_reading_i};
    end
  end

  always_comb begin
    case (ptr_q)
      chg_pkg::ADDR_LIMIT_CTRL:   rdata = lim_if.ctrl;
      chg_pkg::ADDR_BATTERY_VOLTAGE_READING_RESULT:  rdata = battery_voltage_reading_q;
      chg_pkg::ADDR_SYSTEM_VOLTAGE_READING_RESULT:  rdata = system_voltage_reading_q;
      chg_pkg::ADDR_INPUT_VOLTAGE_READING_RESULT: rdata = input_voltage_reading_q;
      chg_pkg::ADDR_ICHG_RESULT:  rdata = ichg_q;
      chg_pkg::ADDR_REG_RESET:    rdata = 8'h00;
      default:                    rdata = chg_pkg::READ_UNMAPPED;
    endcase
  end

  // Serial target: a write's first data byte loads the pointer, later
  // bytes write and step it; reads step it after every byte sent.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q   <= chg_pkg::CHG_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      nack_q    <= 1'b0;
      oe_q      <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (bus_start) begin
        state_q   <= chg_pkg::CHG_ADDR;
        bit_cnt_q <= 4'h0;
        oe_q      <= 1'b0;
      end else if (bus_stop) begin
        state_q <= chg_pkg::CHG_IDLE;
        oe_q    <= 1'b0;
      end else begin
        case (state_q)
          chg_pkg::CHG_IDLE: begin
            oe_q <= 1'b0;
          end
          chg_pkg::CHG_ADDR: begin
            if (scl_rise) begin
              shift_q   <= shift_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall &&
                         bit_cnt_q == chg_pkg::BITS_PER_BYTE) begin
              if (shift_q[7:1] == chg_pkg::BUS_TARGET_ADDR) begin
                rw_q    <= shift_q[0];
                oe_q    <= 1'b1;
                state_q <= chg_pkg::CHG_ADDR_ACK;
              end else begin
                state_q <= chg_pkg::CHG_IDLE;
              end
            end
          end
          chg_pkg::CHG_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q    <= rdata;
                oe_q    <= ~rdata[7];
                state_q <= chg_pkg::CHG_RD_BYTE;
              end else begin
                oe_q    <= 1'b0;
                first_q <= 1'b1;
                state_q <= chg_pkg::CHG_WR_BYTE;
              end
            end
          end
          chg_pkg::CHG_WR_BYTE: begin
            if (scl_rise) begin
              shift_q   <= shift_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall &&
                         bit_cnt_q == chg_pkg::BITS_PER_BYTE) begin
              oe_q    <= 1'b1;
              state_q <= chg_pkg::CHG_WR_ACK;
              first_q <= 1'b0;
              if (first_q) begin
                ptr_q <= shift_q;
              end else begin
                wr_stb_q  <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q     <= ptr_q + 8'h01;
              end
            end
          end
          chg_pkg::CHG_WR_ACK: begin
            if (scl_fall) begin
              oe_q      <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= chg_pkg::CHG_WR_BYTE;
            end
          end
          chg_pkg::CHG_RD_BYTE: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_q == chg_pkg::BITS_PER_BYTE) begin
                oe_q    <= 1'b0;
                ptr_q   <= ptr_q + 8'h01;
                state_q <= chg_pkg::CHG_RD_ACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= ~tx_q[6];
              end
            end
          end
          chg_pkg::CHG_RD_ACK: begin
            if (scl_rise) begin
              nack_q <= sda_i;
            end else if (scl_fall) begin
              if (nack_q) begin
                state_q <= chg_pkg::CHG_IDLE;
              end else begin
                tx_q      <= rdata;
                oe_q      <= ~rdata[7];
                bit_cnt_q <= 4'h0;
                state_q   <= chg_pkg::CHG_RD_BYTE;
              end
            end
          end
          default: begin
            state_q <= chg_pkg::CHG_IDLE;
            oe_q    <= 1'b0;
          end
        endcase
      end
    end
  end

  // Writes to result registers decode to nothing and are simply dropped.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lim_wr_q <= 1'b0;
    end else begin
      lim_wr_q <= wr_stb_q &&
                  wr_addr_q == chg_pkg::ADDR_LIMIT_CTRL;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= wr_stb_q && wr_addr_q == chg_pkg::ADDR_REG_RESET &&
                   wr_data_q[chg_pkg::REG_RESET_BIT];
    end
  end

  assign lim_if.wr_stb  = lim_wr_q;
  assign lim_if.wr_data = wr_data_q;
  assign lim_if.reg_rst = rst_req_q;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_q <= 1'b0;
    end else begin
      timer_q <= rst_req_q;
    end
  end

  // The pin flop lags the state decision by one cycle; bus phases last many
  // system clocks, so the data line still settles while the bus clock is low.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_o <= oe_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      absolute_limit_select_o         <= 1'b0;
      input_voltage_limit_threshold_o <= chg_pkg::LIMIT_CTRL_RESET[6:0];
      safety_timer_restart_o          <= 1'b0;
    end else begin
      absolute_limit_select_o         <= lim_if.ctrl[chg_pkg::MODE_BIT];
      input_voltage_limit_threshold_o <= lim_if.eff_threshold;
      safety_timer_restart_o          <= timer_q;
    end
  end

endmodule

// >>> design/chg_limit_reg.sv
// Input voltage limit control register: mode bit and threshold field.
// Assumes strobes from the register slice top on the same clock.
module chg_limit_reg (
  input  wire logic  sys_clk_i,
  input  wire logic  resetn_i,
  input  wire logic [6:0] rel_code_i,
  chg_lim_if.lim     lim
);

  logic       mode_q;
  logic [6:0] thr_q;
  logic [6:0] eff_q;
  logic [6:0] rel_clamped;
  logic [6:0] thr_clamped;

  always_comb begin
    rel_clamped = (rel_code_i < chg_pkg::LIMIT_MIN_CODE) ?
                  chg_pkg::LIMIT_MIN_CODE : rel_code_i;
    thr_clamped = (thr_q < chg_pkg::LIMIT_MIN_CODE) ?
                  chg_pkg::LIMIT_MIN_CODE : thr_q;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= chg_pkg::LIMIT_CTRL_RESET[chg_pkg::MODE_BIT];
    end else if (lim.reg_rst) begin
      mode_q <= chg_pkg::LIMIT_CTRL_RESET[chg_pkg::MODE_BIT];
    end else if (lim.wr_stb) begin
      mode_q <= lim.wr_data[chg_pkg::MODE_BIT];
    end
  end

  // A write that selects absolute mode also lands its threshold, so the
  // host can switch modes and set the level in one transfer.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      thr_q <= chg_pkg::LIMIT_CTRL_RESET[6:0];
    end else if (lim.reg_rst) begin
      thr_q <= chg_pkg::LIMIT_CTRL_RESET[6:0];
    end else if (lim.wr_stb && lim.wr_data[chg_pkg::MODE_BIT]) begin
      thr_q <= lim.wr_data[6:0];
    end else if (!mode_q) begin
      thr_q <= rel_code_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      eff_q <= chg_pkg::LIMIT_CTRL_RESET[6:0];
    end else begin
      eff_q <= mode_q ? thr_clamped : rel_clamped;
    end
  end

  assign lim.ctrl          = {mode_q, thr_q};
  assign lim.eff_threshold = eff_q;

endmodule

// >>> shared/chg_lim_if.sv
// Carrier between the register slice top and the input limit control.
// Assumes both ends run on the same system clock.
interface chg_lim_if;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       reg_rst;
  logic [7:0] ctrl;
  logic [6:0] eff_threshold;

  modport bank (output wr_stb, output wr_data, output reg_rst,
                input  ctrl, input eff_threshold);
  modport lim  (input  wr_stb, input wr_data, input reg_rst,
                output ctrl, output eff_threshold);
endinterface

// >>> shared/chg_pkg.sv
// Constants shared by the charger register slice and its limit control.
// Assumes one system clock and an active-low asynchronous reset.
package chg_pkg;

  localparam logic [7:0] ADDR_LIMIT_CTRL   = 8'h0D;
  localparam logic [7:0] ADDR_BATTERY_VOLTAGE_READING_RESULT  = 8'h0E;
  localparam logic [7:0] ADDR_SYSTEM_VOLTAGE_READING_RESULT  = 8'h0F;
  localparam logic [7:0] ADDR_INPUT_VOLTAGE_READING_RESULT = 8'h11;
  localparam logic [7:0] ADDR_ICHG_RESULT  = 8'h12;
  localparam logic [7:0] ADDR_REG_RESET    = 8'h14;

  localparam int         MODE_BIT          = 7;
  localparam int         FLAG_BIT          = 7;
  localparam int         REG_RESET_BIT     = 7;

  localparam logic [7:0] LIMIT_CTRL_RESET  = 8'h12;
  localparam logic [6:0] LIMIT_MIN_CODE    = 7'h0D;
  localparam logic [6:0] RESULT_RESET      = 7'h00;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;

  // Serial bus target address; the value is arbitrary.
  localparam logic [6:0] BUS_TARGET_ADDR   = 7'h55;
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

  typedef enum logic [2:0] {
    CHG_IDLE,
    CHG_ADDR,
    CHG_ADDR_ACK,
    CHG_WR_BYTE,
    CHG_WR_ACK,
    CHG_RD_BYTE,
    CHG_RD_ACK
  } chg_bus_state_t;

endpackage

// >>> sim/chg_dpm_adc_regs_assertions.sv
// Checker for the charger register slice, watching its top ports only.
// Assumes one clock and an active-low asynchronous reset.
module chg_dpm_adc_regs_chk (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [6:0] rel_limit_code_i,
  input wire logic       thermal_regulation_flag_i,
  input wire logic [6:0] battery_voltage_reading_i,
  input wire logic [6:0] system_voltage_reading_i,
  input wire logic       input_supply_present_i,
  input wire logic [6:0] input_voltage_reading_i,
  input wire logic [6:0] charge_current_reading_i,
  input wire logic       below_battery_short_threshold_i,
  input wire logic       absolute_limit_select_o,
  input wire logic [6:0] input_voltage_limit_threshold_o,
  input wire logic       safety_timer_restart_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_rel_steady;
    (!absolute_limit_select_o && $stable(rel_limit_code_i)) [*6];
  endsequence

  a_thr_floor: assert property (
    input_voltage_limit_threshold_o >= chg_pkg::LIMIT_MIN_CODE)
    else $error("threshold below floor");
  a_rel_track: assert property (
    s_rel_steady |-> input_voltage_limit_threshold_o ==
      (rel_limit_code_i < 7'h0D ? 7'h0D : rel_limit_code_i))
    else $error("threshold not tracking relative code");
  a_abs_hold: assert property (
    absolute_limit_select_o && $past(absolute_limit_select_o) &&
    $changed(rel_limit_code_i) |=> $stable(input_voltage_limit_threshold_o))
    else $error("absolute threshold moved with relative code");
  a_mode_scl_low: assert property (
    $changed(absolute_limit_select_o) |-> !scl_i)
    else $error("mode changed outside a bus write");
  a_sda_low_only: assert property (
    !sda_o)
    else $error("data line driven high");
  a_oe_scl_low: assert property (
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data line moved while bus clock high");
  a_restart_pulse: assert property (
    $rose(safety_timer_restart_o) |=> !safety_timer_restart_o)
    else $error("restart pulse longer than one cycle");
  a_restart_mode: assert property (
    safety_timer_restart_o |-> ##[0:4] !absolute_limit_select_o)
    else $error("register reset kept absolute mode");
endmodule

bind chg_dpm_adc_regs chg_dpm_adc_regs_chk i_chk (
  .sys_clk_i, .resetn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .rel_limit_code_i, .thermal_regulation_flag_i, .battery_voltage_reading_i,
  .system_voltage_reading_i, .input_supply_present_i,
  .input_voltage_reading_i, .charge_current_reading_i,
  .below_battery_short_threshold_i, .absolute_limit_select_o,
  .input_voltage_limit_threshold_o, .safety_timer_restart_o);

// >>> sim/chg_dpm_adc_regs_tb.sv
// Testbench for the charger register slice, driven over the two-wire bus.
// Assumes the host model and checker files are compiled before this one.
module chg_dpm_adc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [6:0] rel_code = 7'h12;
  logic       therm = 1'b0;
  logic [6:0] battery_voltage_reading = 7'h00;
  logic [6:0] system_voltage_reading = 7'h00;
  logic       vbus_ok = 1'b0;
  logic [6:0] input_voltage_reading = 7'h00;
  logic [6:0] ichg = 7'h00;
  logic       bat_short = 1'b0;
  logic       scl, sda_line, sda_o, sda_oe, abs_sel, restart;
  logic [6:0] thr;
  logic [7:0] code;
  logic [7:0] codes [3] = '{8'h8C, 8'h8D, 8'hFF};
  int         n_fail, cmp_count, restarts;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (restart === 1'b1) restarts++;

  chg_host_model i_host (.sys_clk_i(sys_clk), .sda_oe_i(sda_oe),
                         .scl_o(scl), .sda_line_o(sda_line));
  chg_dpm_adc_regs i_dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .rel_limit_code_i(rel_code),
    .thermal_regulation_flag_i(therm), .battery_voltage_reading_i(battery_voltage_reading),
    .system_voltage_reading_i(system_voltage_reading), .input_supply_present_i(vbus_ok),
    .input_voltage_reading_i(input_voltage_reading), .charge_current_reading_i(ichg),
    .below_battery_short_threshold_i(bat_short),
    .absolute_limit_select_o(abs_sel),
    .input_voltage_limit_threshold_o(thr),
    .safety_timer_restart_o(restart));

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_ok(input logic [7:0] p, input logic [7:0] d);
    i_host.wr(chg_pkg::BUS_TARGET_ADDR, p, d);
    cmp_byte({7'h00, i_host.nack_q}, 8'h00);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    i_host.rd(p, 1);
    cmp_byte(i_host.rx_q.pop_front(), e);
  endtask

  // Bus traffic dominates run time; this bound leaves ample margin.
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd_chk(chg_pkg::ADDR_LIMIT_CTRL, chg_pkg::LIMIT_CTRL_RESET);
    rel_code <= 7'h20;
    wr_ok(chg_pkg::ADDR_LIMIT_CTRL, 8'h05);
    rd_chk(chg_pkg::ADDR_LIMIT_CTRL, 8'h20);
    cmp_byte({abs_sel, thr}, 8'h20);
    rel_code <= 7'h03;
    rd_chk(chg_pkg::ADDR_LIMIT_CTRL, 8'h03);
    cmp_byte({abs_sel, thr}, 8'h0D);
    rel_code <= 7'h40;
    foreach (codes[j]) begin
      code = codes[j];
      wr_ok(chg_pkg::ADDR_LIMIT_CTRL, code);
      rd_chk(chg_pkg::ADDR_LIMIT_CTRL, code);
      cmp_byte({abs_sel, thr}, code[6:0] < 7'h0D ? 8'h8D : code);
    end
    rel_code <= 7'h33;
    i_host.wr(7'h2A, chg_pkg::ADDR_LIMIT_CTRL, 8'h05);
    cmp_byte({7'h00, i_host.nack_q}, 8'h01);
    wr_ok(chg_pkg::ADDR_REG_RESET, 8'h00);
    cmp_byte({abs_sel, thr}, 8'hFF);
    rel_code <= 7'h40;
    wr_ok(chg_pkg::ADDR_REG_RESET, 8'h80);
    cmp_byte({abs_sel, thr}, 8'h40);
    rd_chk(chg_pkg::ADDR_REG_RESET, 8'h00);
    cmp_byte(restarts[7:0], 8'h01);
    for (int i = 0; i < 2; i++) begin
      therm <= i[0];
      vbus_ok <= i[0];
      battery_voltage_reading <= 7'h2A ^ {7{i[0]}};
      system_voltage_reading <= 7'h55 ^ {7{i[0]}};
      input_voltage_reading <= 7'h7F ^ {7{i[0]}};
      ichg <= 7'h33 ^ {7{i[0]}};
      @(posedge sys_clk);
      i_host.rd(chg_pkg::ADDR_BATTERY_VOLTAGE_READING_RESULT, 5);
      cmp_byte(i_host.rx_q.pop_front(), {therm, battery_voltage_reading});
      cmp_byte(i_host.rx_q.pop_front(), {1'b0, system_voltage_reading});
      cmp_byte(i_host.rx_q.pop_front(), chg_pkg::READ_UNMAPPED);
      cmp_byte(i_host.rx_q.pop_front(), {vbus_ok, input_voltage_reading});
      cmp_byte(i_host.rx_q.pop_front(), {1'b0, ichg});
    end
    bat_short <= 1'b1;
    rd_chk(chg_pkg::ADDR_ICHG_RESULT, 8'h00);
    bat_short <= 1'b0;
    wr_ok(chg_pkg::ADDR_SYSTEM_VOLTAGE_READING_RESULT, 8'hFF);
    wr_ok(chg_pkg::ADDR_ICHG_RESULT, 8'hFF);
    rd_chk(chg_pkg::ADDR_SYSTEM_VOLTAGE_READING_RESULT, {1'b0, system_voltage_reading});
    rd_chk(chg_pkg::ADDR_ICHG_RESULT, {1'b0, ichg});
    cmp_byte({abs_sel, thr}, 8'h40);
    stop_test();
  end
endmodule

// >>> sim/chg_host_model.sv
// Host model: two-wire bus master with register write and read tasks.
// Assumes a pulled-up data line and a bus clock far slower than sys_clk.
module chg_host_model (
  input  wire logic sys_clk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sda_q = 1'b1;
  logic       nack_q;
  logic [7:0] rx_q [$];

  // The line follows the host's level unless the target pulls it low.
  assign sda_line_o = sda_oe_i ? 1'b0 : sda_q;
  initial scl_o = 1'b1;

  task automatic lvl(input logic c, input logic d);
    scl_o <= c;
    sda_q <= d;
    repeat (10) @(posedge sys_clk_i);
  endtask

  // Data moves only while the bus clock is low, so no false start.
  task automatic bit_x(input logic d, output logic r);
    lvl(1'b0, sda_q);
    lvl(1'b0, d);
    lvl(1'b1, d);
    r = sda_line_o;
  endtask

  task automatic start();
    lvl(1'b0, sda_q);
    lvl(1'b0, 1'b1);
    lvl(1'b1, 1'b1);
    lvl(1'b1, 1'b0);
  endtask

  task automatic stop();
    lvl(1'b0, sda_q);
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b0);
    lvl(1'b1, 1'b1);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic h,
                      output logic [7:0] rx, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(h, a);
  endtask

  task automatic wr(input logic [6:0] ta, input logic [7:0] p, d);
    logic [7:0] x;
    logic       a0, a1, a2;
    start();
    xfer({ta, 1'b0}, 1'b1, x, a0);
    xfer(p, 1'b1, x, a1);
    xfer(d, 1'b1, x, a2);
    stop();
    nack_q = a0 | a1 | a2;
  endtask

  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] x;
    logic       a;
    start();
    xfer({chg_pkg::BUS_TARGET_ADDR, 1'b0}, 1'b1, x, a);
    xfer(p, 1'b1, x, a);
    start();
    xfer({chg_pkg::BUS_TARGET_ADDR, 1'b1}, 1'b1, x, a);
    for (int k = 0; k < n; k++) begin
      xfer(8'hFF, k == n - 1, x, a);
      rx_q.push_back(x);
    end
    stop();
  endtask
endmodule
